// ===== core/dmacc_pkg.sv
// dmacc_pkg: offsets, field positions, codes and carrier types of the
// six-channel dma counting/index block; assumes a 16-bit cpu mmr bus
package dmacc_pkg;
  localparam int NCH = 6;
  localparam int NSLOT = 5;
  localparam int NGLOB = 10;
  // cpu memory-mapped offsets
  localparam logic [7:0] A_PREC = 8'h54;
  localparam logic [7:0] A_SBP = 8'h55;
  localparam logic [7:0] A_SDI = 8'h56;
  localparam logic [7:0] A_SDN = 8'h57;
  // subbank: channel i slot s at i*5+s, globals from 1eh on
  localparam int SUB_GLOB = 'h1e;
  localparam int G_IDX0 = 2;
  localparam int G_IDX1 = 3;
  localparam int G_FRI0 = 4;
  localparam int G_FRI1 = 5;
  localparam int G_GSA = 6;
  localparam int G_GDA = 7;
  localparam int G_GCR = 8;
  localparam int G_GFR = 9;
  // channel_mode_control fields
  localparam int M_AUTO = 15;
  localparam int M_IE = 14;
  localparam int M_IRQ_MODE_BIT = 13;
  localparam int M_ABU = 12;
  localparam int M_SOURCE_INDEX_SELECT = 8;
  localparam int M_DEST_INDEX_SELECT = 2;
  // sync_frame_count_reg fields
  localparam int F_SYNC = 12;
  localparam int F_DBL = 11;
  localparam int F_FC = 0;
  // channel_priority_enable fields
  localparam int P_EN = 0;
  localparam int P_ISEL = 6;
  localparam int P_PRIO = 8;
  localparam logic [15:0] PREC_RST = 16'h0000;
  // index select codes
  localparam logic [2:0] IX_INC = 3'h1;
  localparam logic [2:0] IX_DEC = 3'h2;
  localparam logic [2:0] IX_SET0 = 3'h3;
  localparam logic [2:0] IX_SET1 = 3'h4;
  // trigger_select codes
  localparam logic [3:0] SY_NONE = 4'h0;
  localparam logic [3:0] SY_S0RX = 4'h1;
  localparam logic [3:0] SY_S0TX = 4'h2;
  localparam logic [3:0] SY_S1RX = 4'h5;
  localparam logic [3:0] SY_S1TX = 4'h6;
  localparam logic [3:0] SY_TIM0 = 4'hd;
  localparam logic [3:0] SY_EXT3 = 4'he;
  localparam logic [3:0] SY_TIM1 = 4'hf;
  // irq_route_select codes
  localparam logic [1:0] IR_PERIPH = 2'h0;
  localparam logic [1:0] IR_MIXED = 2'h1;
  localparam logic [1:0] IR_DMA = 2'h2;

  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] ctr;
    logic [15:0] sfc;
    logic [15:0] mcr;
  } dmacc_chan_t;

  typedef struct packed {
    logic s0rx;
    logic s0tx;
    logic s1rx;
    logic s1tx;
    logic tim0;
    logic ext3;
    logic tim1;
  } dmacc_sync_t;

  typedef struct packed {
    logic timer1;
    logic ser1_rx;
    logic ser1_tx;
  } dmacc_shared_t;

  typedef struct packed {
    logic line6;
    logic line7;
    logic line10;
    logic line11;
    logic chan4;
    logic chan5;
  } dmacc_irq_t;

  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0] chan;
    logic half;
  } dmacc_xfer_t;
endpackage

// ===== core/dmacc_core.sv
// dmacc_core: six dma channels with counters, index stepping, doubleword,
// trigger selection and interrupt routing behind the cpu mmr port.
// assumes sync and shared irq inputs come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each channel keeps an 8-bit frame count field in its sync register
// - frame count drops at the last read of each frame
// - auto reload brings frame count back from global frame reload
// - frame count zero means the block is one frame
// - 16-bit element count, all ones gives 65536 elements per frame
// - element count drops after every element read
// - auto reload brings element count back from global element reload
// - doubleword issues two 16-bit transfers, addresses step after each
// - a doubleword counts as one element
// - source and dest index selects pick the step registers
// - non-final transfers add the selected element step
// - the final transfer of a frame adds the selected frame step
// - enable bit zero blocks channel interrupts whatever the mode bit
// - auto-buffering: full buffer only, or half and full with mode set
// - multi-frame: block end only, or every frame end with mode set
// - trigger codes none, serial 0 rx/tx, serial 1 rx/tx; 3-4 reserved
// - codes d, e, f pick timer 0, external 3, timer 1
// - channels 2, 3 share lines 10, 11; channel 1 shares line 7
// - reset deselects channel 0-3 interrupts from shared lines
// - 2-bit route select drives lines 6, 7, 10, 11; code 11 reserved
// - subbank pointer picks the register a data port access reaches
// - autoincrement port bumps the pointer after access, plain port not
// - channels of equal priority are served round robin
module dmacc_core
  import dmacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] mmr_addr_i,
  input wire logic mmr_wr_i,
  input wire logic mmr_rd_i,
  input wire logic [15:0] mmr_wdata_i,
  output logic [15:0] mmr_rdata_o,
  input wire dmacc_sync_t sync_i,
  input wire dmacc_shared_t shared_i,
  output dmacc_irq_t irq_o,
  output logic mem_req_o,
  output dmacc_xfer_t mem_xfer_o,
  input wire logic mem_ack_i
);
  typedef enum {ST_IDLE, ST_XFER} dmacc_state_t;

  dmacc_state_t st_q, st_d;
  dmacc_chan_t chan_q [NCH];
  dmacc_chan_t chan_d [NCH];
  logic [15:0] glob_q [NGLOB];
  logic [15:0] glob_d [NGLOB];
  logic [15:0] prec_q, prec_d;
  logic [15:0] sbp_q, sbp_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] msrc_q, msrc_d;
  logic [15:0] mdst_q, mdst_d;
  logic [NCH-1:0] pend_q, pend_d;
  logic [NCH-1:0] cirq_q, cirq_d;
  logic [2:0] cur_q, cur_d;
  logic [2:0] last_q, last_d;
  logic half_q, half_d;
  logic req_q, req_d;
  dmacc_irq_t irq_q, irq_d;
  logic [NCH-1:0] elig;
  logic grant;
  logic [2:0] gnt_ch;
  logic [15:0] sub_rd;

  function automatic logic sync_hit(input logic [3:0] code,
                                    input dmacc_sync_t s);
    logic r;
    r = 1'b0;
    case (code)
      SY_S0RX: r = s.s0rx;
      SY_S0TX: r = s.s0tx;
      SY_S1RX: r = s.s1rx;
      SY_S1TX: r = s.s1tx;
      SY_TIM0: r = s.tim0;
      SY_EXT3: r = s.ext3;
      SY_TIM1: r = s.tim1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // plain +1/-1 ignore frame end; set0/set1 switch to frame step at end
  function automatic logic [15:0] step(input logic [2:0] m,
                                       input logic fin,
                                       input logic [15:0] e0,
                                       input logic [15:0] e1,
                                       input logic [15:0] f0,
                                       input logic [15:0] f1);
    logic [15:0] r;
    r = 16'h0000;
    case (m)
      IX_INC: r = 16'h0001;
      IX_DEC: r = 16'hffff;
      IX_SET0: r = fin ? f0 : e0;
      IX_SET1: r = fin ? f1 : e1;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // trigger latch; a new event in the grant cycle survives
  always_comb
  begin
    pend_d = pend_q;
    for (int i = 0; i < NCH; i++)
    begin
      if (grant && gnt_ch == 3'(i))
        pend_d[i] = 1'b0;
      if (sync_hit(chan_q[i].sfc[F_SYNC+:4], sync_i))
        pend_d[i] = 1'b1;
    end
  end

  // high priority group first, then low, each scanned from last winner
  always_comb
  begin
    logic [2:0] c;
    c = 3'h0;
    grant = 1'b0;
    gnt_ch = last_q;
    for (int i = 0; i < NCH; i++)
      elig[i] = prec_q[P_EN+i] &&
                (chan_q[i].sfc[F_SYNC+:4] == SY_NONE || pend_q[i]);
    if (st_q == ST_IDLE)
      for (int p = 1; p >= 0; p--)
        for (int k = 1; k <= NCH; k++)
        begin
          c = 3'((int'(last_q) + k) % NCH);
          if (!grant && elig[c] && prec_q[P_PRIO+int'(c)] == p[0])
          begin
            grant = 1'b1;
            gnt_ch = c;
          end
        end
  end

  always_comb
  begin
    dmacc_chan_t c;
    logic dbl, fin, fend, bend, hmark, auto_buffering;
    c = chan_q[cur_q];
    dbl = c.sfc[F_DBL];
    auto_buffering = c.mcr[M_ABU];
    fin = 1'b0;
    fend = 1'b0;
    bend = 1'b0;
    hmark = 1'b0;
    chan_d = chan_q;
    glob_d = glob_q;
    prec_d = prec_q;
    sbp_d = sbp_q;
    st_d = st_q;
    cur_d = cur_q;
    last_d = last_q;
    half_d = half_q;
    req_d = req_q;
    msrc_d = msrc_q;
    mdst_d = mdst_q;
    cirq_d = '0;
    unique case (st_q)
      ST_IDLE:
        if (grant)
        begin
          st_d = ST_XFER;
          cur_d = gnt_ch;
          last_d = gnt_ch;
          half_d = 1'b0;
          req_d = 1'b1;
          msrc_d = chan_q[gnt_ch].src;
          mdst_d = chan_q[gnt_ch].dst;
        end
      ST_XFER:
        if (mem_ack_i)
        begin
          fin = c.ctr == 16'h0000 && (!dbl || half_q);
          c.src = c.src + step(c.mcr[M_SOURCE_INDEX_SELECT+:3], fin, glob_q[G_IDX0],
            glob_q[G_IDX1], glob_q[G_FRI0], glob_q[G_FRI1]);
          c.dst = c.dst + step(c.mcr[M_DEST_INDEX_SELECT+:3], fin, glob_q[G_IDX0],
            glob_q[G_IDX1], glob_q[G_FRI0], glob_q[G_FRI1]);
          if (dbl && !half_q)
          begin
            // second word follows at once, no new trigger needed
            half_d = 1'b1;
            msrc_d = c.src;
            mdst_d = c.dst;
          end
          else
          begin
            req_d = 1'b0;
            st_d = ST_IDLE;
            if (c.ctr != 16'h0000)
              c.ctr = c.ctr - 16'h0001;
            else
            begin
              fend = 1'b1;
              if (auto_buffering || c.sfc[F_FC+:8] == 8'h00)
                bend = 1'b1;
              else
              begin
                c.sfc[F_FC+:8] = c.sfc[F_FC+:8] - 8'h01;
                c.ctr = glob_q[G_GCR];
              end
            end
            hmark = auto_buffering && !bend && c.ctr == {1'b0, glob_q[G_GCR][15:1]};
            if (bend)
            begin
              if (c.mcr[M_AUTO])
              begin
                c.ctr = glob_q[G_GCR];
                c.sfc[F_FC+:8] = glob_q[G_GFR][7:0];
                c.src = glob_q[G_GSA];
                c.dst = glob_q[G_GDA];
              end
              else
                prec_d[P_EN+int'(cur_q)] = 1'b0;
            end
            cirq_d[cur_q] = c.mcr[M_IE] && (bend || (c.mcr[M_IRQ_MODE_BIT] &&
              (auto_buffering ? hmark : fend)));
          end
          chan_d[cur_q] = c;
        end
    endcase
    // cpu writes win over the engine update in the same cycle
    if (mmr_wr_i && mmr_addr_i == A_PREC)
      prec_d = mmr_wdata_i;
    if (mmr_wr_i && mmr_addr_i == A_SBP)
      sbp_d = mmr_wdata_i;
    if (mmr_wr_i && (mmr_addr_i == A_SDI || mmr_addr_i == A_SDN))
    begin
      for (int i = 0; i < NCH; i++)
        for (int s = 0; s < NSLOT; s++)
          if (sbp_q == 16'(i * NSLOT + s))
            chan_d[i][16*(NSLOT-1-s) +: 16] = mmr_wdata_i;
      for (int g = 0; g < NGLOB; g++)
        if (sbp_q == 16'(SUB_GLOB + g))
          glob_d[g] = mmr_wdata_i;
    end
    if ((mmr_wr_i || mmr_rd_i) && mmr_addr_i == A_SDI)
      sbp_d = sbp_q + 16'h0001;
  end

  // unmapped subaddresses read as zero
  always_comb
  begin
    sub_rd = 16'h0000;
    for (int i = 0; i < NCH; i++)
      for (int s = 0; s < NSLOT; s++)
        if (sbp_q == 16'(i * NSLOT + s))
          sub_rd = chan_q[i][16*(NSLOT-1-s) +: 16];
    for (int g = 0; g < NGLOB; g++)
      if (sbp_q == 16'(SUB_GLOB + g))
        sub_rd = glob_q[g];
  end

  always_comb
  begin
    rdata_d = rdata_q;
    if (mmr_rd_i)
    begin
      rdata_d = 16'h0000;
      if (mmr_addr_i == A_PREC)
        rdata_d = prec_q;
      if (mmr_addr_i == A_SBP)
        rdata_d = sbp_q;
      if (mmr_addr_i == A_SDI || mmr_addr_i == A_SDN)
        rdata_d = sub_rd;
    end
  end

  always_comb
  begin
    irq_d.chan4 = cirq_q[4];
    irq_d.chan5 = cirq_q[5];
    case (prec_q[P_ISEL+:2])
      IR_PERIPH:
      begin
        irq_d.line6 = 1'b0;
        irq_d.line7 = shared_i.timer1;
        irq_d.line10 = shared_i.ser1_rx;
        irq_d.line11 = shared_i.ser1_tx;
      end
      IR_MIXED:
      begin
        irq_d.line6 = 1'b0;
        irq_d.line7 = shared_i.timer1;
        irq_d.line10 = cirq_q[2];
        irq_d.line11 = cirq_q[3];
      end
      IR_DMA:
      begin
        irq_d.line6 = cirq_q[0];
        irq_d.line7 = cirq_q[1];
        irq_d.line10 = cirq_q[2];
        irq_d.line11 = cirq_q[3];
      end
      default:
      begin
        // reserved route code drives nothing on the shared lines
        irq_d.line6 = 1'b0;
        irq_d.line7 = 1'b0;
        irq_d.line10 = 1'b0;
        irq_d.line11 = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_q <= ST_IDLE;
      for (int i = 0; i < NCH; i++)
        chan_q[i] <= '0;
      for (int g = 0; g < NGLOB; g++)
        glob_q[g] <= 16'h0000;
      prec_q <= PREC_RST;
      sbp_q <= 16'h0000;
      rdata_q <= 16'h0000;
      msrc_q <= 16'h0000;
      mdst_q <= 16'h0000;
      pend_q <= '0;
      cirq_q <= '0;
      cur_q <= 3'h0;
      last_q <= 3'h0;
      half_q <= 1'b0;
      req_q <= 1'b0;
      irq_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      chan_q <= chan_d;
      glob_q <= glob_d;
      prec_q <= prec_d;
      sbp_q <= sbp_d;
      rdata_q <= rdata_d;
      msrc_q <= msrc_d;
      mdst_q <= mdst_d;
      pend_q <= pend_d;
      cirq_q <= cirq_d;
      cur_q <= cur_d;
      last_q <= last_d;
      half_q <= half_d;
      req_q <= req_d;
      irq_q <= irq_d;
    end
  end

  assign mmr_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign mem_req_o = req_q;
  assign mem_xfer_o = '{src: msrc_q, dst: mdst_q, chan: cur_q, half: half_q};
endmodule

`default_nettype wire

// ===== tb/dmacc_core_asserts.sv
// dmacc_core_asserts: port-level checks of dmacc_core, bound below
// assumes the single clk_i domain and synchronous reset_i
`timescale 1ns/1ps
`default_nettype none
module dmacc_core_asserts
  import dmacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] mmr_addr_i,
  input wire logic mmr_wr_i,
  input wire logic mmr_rd_i,
  input wire logic [15:0] mmr_wdata_i,
  input wire logic [15:0] mmr_rdata_o,
  input wire dmacc_sync_t sync_i,
  input wire dmacc_shared_t shared_i,
  input wire dmacc_irq_t irq_o,
  input wire logic mem_req_o,
  input wire dmacc_xfer_t mem_xfer_o,
  input wire logic mem_ack_i
);
  // shadow of the route field, updated on the same edge as the design's
  logic [1:0] route_q;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      route_q <= IR_PERIPH;
    else if (mmr_wr_i && mmr_addr_i == A_PREC)
      route_q <= mmr_wdata_i[7:6];
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_drop;
    $fell(mem_req_o);
  endsequence
  sequence s_last_half;
    mem_req_o && mem_ack_i && mem_xfer_o.half;
  endsequence
  reset_clear_a: assert property ($fell(reset_i) |->
    !mem_req_o && irq_o == '0) else $error("outputs not clear");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_xfer_o)) else $error("request dropped");
  req_gap_a: assert property (s_drop |-> $past(mem_ack_i))
    else $error("request dropped without ack");
  half_end_a: assert property (s_last_half |=> !mem_req_o)
    else $error("third word after doubleword");
  unmapped_rd_a: assert property (mmr_rd_i &&
    (mmr_addr_i < A_PREC || mmr_addr_i > A_SDN) |=>
    mmr_rdata_o == 16'h0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!mmr_rd_i |=> $stable(mmr_rdata_o))
    else $error("read data moved");
  line7_share_a: assert property (route_q != IR_DMA |=>
    irq_o.line7 == $past(shared_i.timer1)) else $error("line7 wrong");
  serial_share_a: assert property (route_q == IR_PERIPH |=>
    irq_o.line10 == $past(shared_i.ser1_rx) &&
    irq_o.line11 == $past(shared_i.ser1_tx)) else $error("line10 11 wrong");
  line6_quiet_a: assert property (route_q != IR_DMA |=> !irq_o.line6)
    else $error("line6 raised");
  irq_pulse_a: assert property ($rose(irq_o.chan4) |=> !irq_o.chan4)
    else $error("chan4 pulse too long");
endmodule
bind dmacc_core dmacc_core_asserts i_dmacc_core_asserts(.clk_i, .reset_i,
  .mmr_addr_i, .mmr_wr_i, .mmr_rd_i, .mmr_wdata_i, .mmr_rdata_o, .sync_i,
  .shared_i, .irq_o, .mem_req_o, .mem_xfer_o, .mem_ack_i);
`default_nettype wire

// ===== tb/dmacc_mem_model.sv
// dmacc_mem_model: memory side of the transfer port, acks each word
// assumes one open request at a time; slow_i stretches the wait
`timescale 1ns/1ps
`default_nettype none
module dmacc_mem_model
  import dmacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire dmacc_xfer_t xfer_i,
  input wire logic slow_i,
  output logic ack_o,
  output int acks_o,
  output int halves_o
);
  logic [1:0] wait_q;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      acks_o <= 0;
      halves_o <= 0;
    end
    else
    begin
      // one-cycle ack, never while idle
      if (req_i && !ack_o)
      begin
        if (wait_q == (slow_i ? 2'h3 : 2'h0))
        begin
          ack_o <= 1'b1;
          wait_q <= 2'h0;
        end
        else
          wait_q <= wait_q + 2'h1;
      end
      else
        ack_o <= 1'b0;
      if (req_i && ack_o)
      begin
        acks_o <= acks_o + 1;
        halves_o <= halves_o + int'(xfer_i.half);
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// tb: programs channels through the mmr port and checks counts,
// addresses and irq lines; assumes dmacc_mem_model on the far side
`timescale 1ns/1ps
`default_nettype none
module tb
  import dmacc_pkg::*;
;
  logic clk_i, reset_i, mwr, mrd, slow, req, ack;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v;
  dmacc_sync_t sync;
  dmacc_shared_t shr;
  dmacc_irq_t irq;
  dmacc_xfer_t xf;
  int acks, halves, n4, n5, mismatches, num_checks, i, k;
  logic [3:0] codes [7] = '{SY_S0RX, SY_S0TX, SY_S1RX, SY_S1TX,
    SY_TIM0, SY_EXT3, SY_TIM1};
  logic [3:0] lines [3] = '{4'h5, 4'h4, 4'h0};
  dmacc_core i_dmacc_core(.clk_i, .reset_i, .mmr_addr_i(addr),
    .mmr_wr_i(mwr), .mmr_rd_i(mrd), .mmr_wdata_i(wdata),
    .mmr_rdata_o(rdata), .sync_i(sync), .shared_i(shr), .irq_o(irq),
    .mem_req_o(req), .mem_xfer_o(xf), .mem_ack_i(ack));
  dmacc_mem_model i_dmacc_mem_model(.clk_i, .reset_i, .req_i(req),
    .xfer_i(xf), .slow_i(slow), .ack_o(ack), .acks_o(acks),
    .halves_o(halves));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (irq.chan4 === 1'b1) n4++;
    if (irq.chan5 === 1'b1) n5++;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    addr = a;
    mrd = 1'b1;
    cyc(1);
    mrd = 1'b0;
    v = rdata;
    cyc(1);
  endtask
  task automatic subrd(input logic [7:0] sa, input logic [15:0] e);
    wr(A_SBP, sa);
    rd(A_SDN);
    chk("subbank", e, v);
  endtask
  task automatic prog(input int ch, input logic [15:0] s, d, c, f, m);
    wr(A_SBP, 8'(ch * NSLOT));
    wr(A_SDI, s);
    wr(A_SDI, d);
    wr(A_SDI, c);
    wr(A_SDI, f);
    wr(A_SDI, m);
  endtask
  task automatic wait_acks(input int n);
    for (i = 0; i < 300 && acks < n; i++) @(posedge clk_i);
    #1;
    chk("acks", 16'(n), 16'(acks));
    if (acks < n) complete_run();
    cyc(6);
  endtask
  initial
  begin
    {reset_i, mwr, mrd, addr, wdata, sync, shr, slow} = '0;
    {mismatches, num_checks, n4, n5} = '0;
    reset_i = 1'b1;
    cyc(10);
    reset_i = 1'b0;
    cyc(2);
    rd(A_PREC);
    chk("prec", PREC_RST, v);
    rd(8'h58);
    chk("unmapped", 16'h0000, v);
    $display("test reset done");
    wr(A_SBP, 8'h20);
    wr(A_SDN, 16'h0002);
    wr(A_SBP, 8'h22);
    wr(A_SDN, 16'h0005);
    // step 0 selects on both sides, irq enabled, two elements one frame
    prog(4, 16'h0010, 16'h0020, 16'h0001, 16'h0000, 16'h430c);
    rd(A_SBP);
    chk("pointer", 16'h0019, v);
    subrd(8'h15, 16'h0020);
    rd(A_SBP);
    chk("plain port", 16'h0015, v);
    slow = 1'b1;
    wr(A_PREC, 16'h0010);
    wait_acks(2);
    subrd(8'h14, 16'h0017);
    subrd(8'h15, 16'h0027);
    rd(A_PREC);
    chk("enable", 16'h0000, v);
    chk("irq4", 16'h0001, 16'(n4));
    $display("test single frame done");
    slow = 1'b0;
    prog(5, 16'h0040, 16'h0050, 16'h0000, 16'h0001, 16'h6104);
    wr(A_PREC, 16'h0020);
    wait_acks(4);
    subrd(8'h1c, 16'h0000);
    subrd(8'h19, 16'h0042);
    chk("irq5", 16'h0002, 16'(n5));
    $display("test two frames done");
    prog(4, 16'h0030, 16'h0060, 16'h0000, 16'h0800, 16'h2104);
    wr(A_PREC, 16'h0010);
    wait_acks(6);
    chk("halves", 16'h0001, 16'(halves));
    subrd(8'h14, 16'h0032);
    chk("irq off", 16'h0001, 16'(n4));
    $display("test doubleword done");
    prog(2, 16'h0070, 16'h0071, 16'h0000, 16'h3000, 16'h0000);
    for (k = 0; k < 7; k++)
    begin
      prog(3, 16'h0070, 16'h0071, 16'h0000, {codes[k], 12'h000}, 16'h0000);
      wr(A_PREC, 16'h000c);
      cyc(8);
      chk("idle", 16'(6 + k), 16'(acks));
      sync = dmacc_sync_t'(7'h40 >> k);
      cyc(1);
      sync = '0;
      wait_acks(7 + k);
    end
    $display("test triggers done");
    // auto reload: one-element block on timer 0 trigger, then reload
    wr(A_SBP, 8'h24);
    wr(A_SDI, 16'h00a0);
    wr(A_SDI, 16'h00b0);
    wr(A_SDI, 16'h0003);
    wr(A_SDI, 16'h0002);
    prog(5, 16'h0080, 16'h0090, 16'h0000, 16'hd000, 16'h8000);
    wr(A_PREC, 16'h0020);
    sync = dmacc_sync_t'(7'h04);
    cyc(1);
    sync = '0;
    wait_acks(14);
    subrd(8'h1b, 16'h0003);
    subrd(8'h1c, 16'hd002);
    subrd(8'h19, 16'h00a0);
    rd(A_PREC);
    chk("auto enable", 16'h0020, v);
    $display("test auto reload done");
    shr = 3'b101;
    for (k = 0; k < 3; k++)
    begin
      wr(A_PREC, {8'h00, 2'(k), 6'h00});
      cyc(2);
      chk("lines", {12'h000, lines[k]},
        {12'h000, irq.line6, irq.line7, irq.line10, irq.line11});
    end
    $display("test irq routing done");
    complete_run();
  end
endmodule
`default_nettype wire
